// >>> src/hadc_ctrl.sv
// headset accessory detect controller: jack, type, pin order, buttons, bias, events
// Operation
// - pin order detection only for four-pole jacks
// - host may force pin order instead
// - report pin order, valid after completion
// - button polling enable and interval 2-500 ms
// - classify button voltage by four thresholds
// - press/release events per button, adc result
// - events maskable, write one clears
// - interrupt raised on any unmasked event
// - interrupt drops once unmasked events cleared
// - four-pole completion turns bias on
// - removal disables and isolates bias rail
// - host bias enable gates the rail
// - status bit shows bias rail up
// - insertion sets inserted event
// - removal sets removed event
// - jack present status follows jack
// - detection latency from rate field
// - latency differs for three and four pole
// - detect pin polarity selectable
// - latency 32/64 ms doubling per code
// - insertion debounce three-bit table
// - removal debounce two-bit table
// - mask gates only interrupt, flags update
`timescale 1ns/100ps
`include "hadc_cfg.svh"

module hadc_ctrl #(
  parameter int TICK_CYCLES = `HADC_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic jack_det_pin,
  input wire logic jack_det_active_high,
  input wire logic accdet_enable,
  input wire logic [2:0] ins_deb_sel,
  input wire logic [1:0] rem_deb_sel,
  input wire logic [1:0] detect_rate_sel,
  input wire logic type_det_auto,
  input wire logic type_force,
  input wire logic type_meas_four,
  input wire logic order_det_auto,
  input wire logic order_force,
  input wire logic order_meas_mic_first,
  input wire logic btn_poll_en,
  input wire logic [8:0] btn_poll_ms,
  input wire logic [7:0] thr_a_d,
  input wire logic [7:0] thr_d_b,
  input wire logic [7:0] thr_b_c,
  input wire logic [7:0] thr_c_mic,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  input wire logic bias_rail_enable,
  input wire logic [10:0] evt_clear,
  input wire logic [10:0] evt_mask,
  output hadc_pkg::hadc_state_type accdet_state,
  output logic [10:0] events,
  output logic jack_present,
  output logic jack_type,
  output logic pin_order,
  output logic gnd_switch,
  output logic bias_drive,
  output logic bias_isolate,
  output logic bias_up,
  output logic [7:0] btn_result,
  output logic adc_req,
  output logic host_irq_out
);
  import hadc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic [9:0] ins_deb_ms(input logic [2:0] sel);
    case (sel)
      3'h0: ins_deb_ms = `HADC_INS_DEB_0;
      3'h1: ins_deb_ms = `HADC_INS_DEB_1;
      3'h2: ins_deb_ms = `HADC_INS_DEB_2;
      3'h3: ins_deb_ms = `HADC_INS_DEB_3;
      3'h4: ins_deb_ms = `HADC_INS_DEB_4;
      3'h5: ins_deb_ms = `HADC_INS_DEB_5;
      3'h6: ins_deb_ms = `HADC_INS_DEB_6;
      default: ins_deb_ms = `HADC_INS_DEB_7;
    endcase
  endfunction

  function automatic logic [9:0] rem_deb_ms(input logic [1:0] sel);
    case (sel)
      2'h0: rem_deb_ms = `HADC_REM_DEB_0;
      2'h1: rem_deb_ms = `HADC_REM_DEB_1;
      2'h2: rem_deb_ms = `HADC_REM_DEB_2;
      default: rem_deb_ms = `HADC_REM_DEB_3;
    endcase
  endfunction

  // three-pole latency, also the extra time a four-pole jack needs
  function automatic logic [9:0] lat3_ms(input logic [1:0] rate);
    lat3_ms = `HADC_LAT3_BASE << rate;
  endfunction

  function automatic logic [9:0] poll_ms(input logic [8:0] req);
    if (req < `HADC_POLL_MIN) begin
      poll_ms = {1'b0, `HADC_POLL_MIN};
    end else if (req > `HADC_POLL_MAX) begin
      poll_ms = {1'b0, `HADC_POLL_MAX};
    end else begin
      poll_ms = {1'b0, req};
    end
  endfunction

  // voltages rise a < d < b < c < mic
  function automatic hadc_btn_type classify(input logic [7:0] v, input logic [7:0] t_ad,
                                            input logic [7:0] t_db, input logic [7:0] t_bc,
                                            input logic [7:0] t_cm);
    if (v < t_ad) begin
      classify = HADC_BTN_A;
    end else if (v < t_db) begin
      classify = HADC_BTN_D;
    end else if (v < t_bc) begin
      classify = HADC_BTN_B;
    end else if (v < t_cm) begin
      classify = HADC_BTN_C;
    end else begin
      classify = HADC_BTN_MIC;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and timer

  hadc_state_reg_type q, d;
  logic t_load;
  logic [9:0] t_ms;
  logic t_done;
  logic jack_s;
  logic [10:0] ev_set;
  hadc_btn_type btn;
  logic [10:0] ev_keep;

  hadc_msdly #(
    .TICK_CYCLES(TICK_CYCLES),
    .MS_W(10)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(t_load),
    .load_ms(t_ms),
    .done(t_done)
  );

  assign jack_s = ~(q.sync2 ^ jack_det_active_high);
  assign btn = classify(adc_data, thr_a_d, thr_d_b, thr_b_c, thr_c_mic);
  assign ev_keep = q.events & ~evt_clear;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    ev_set = '0;
    t_load = 1'b0;
    t_ms = '0;
    d.sync1 = jack_det_pin;
    d.sync2 = q.sync1;
    d.adc_req = 1'b0;
    case (q.state)
      HADC_NO_JACK: begin
        if (accdet_enable && jack_s) begin
          d.state = HADC_INS_DEB;
          t_load = 1'b1;
          t_ms = ins_deb_ms(ins_deb_sel);
        end
      end
      HADC_INS_DEB: begin
        if (!jack_s || !accdet_enable) begin
          d.state = HADC_NO_JACK;
        end else if (t_done) begin
          ev_set[`HADC_EV_INSERTED] = 1'b1;
          d.present = 1'b1;
          d.state = HADC_DETECT;
          d.order_phase = 1'b0;
          t_load = 1'b1;
          t_ms = lat3_ms(detect_rate_sel);
        end
      end
      HADC_DETECT: begin
        if (!jack_s) begin
          d.state = HADC_REM_DEB;
          d.gnd_switch = 1'b0;
          t_load = 1'b1;
          t_ms = rem_deb_ms(rem_deb_sel);
        end else if (t_done && !q.order_phase) begin
          d.jack_type = type_det_auto ? type_meas_four : type_force;
          if (d.jack_type) begin
            // four-pole waits the same again: 64 ms at code 00
            d.order_phase = 1'b1;
            d.gnd_switch = order_det_auto;
            t_load = 1'b1;
            t_ms = lat3_ms(detect_rate_sel);
          end else begin
            ev_set[`HADC_EV_COMPLETE] = 1'b1;
            d.state = HADC_JACK_IN;
            t_load = 1'b1;
            t_ms = poll_ms(btn_poll_ms);
          end
        end else if (t_done) begin
          d.pin_order = order_det_auto ? order_meas_mic_first : order_force;
          d.gnd_switch = 1'b0;
          d.auto_bias = 1'b1;
          ev_set[`HADC_EV_COMPLETE] = 1'b1;
          d.state = HADC_JACK_IN;
          t_load = 1'b1;
          t_ms = poll_ms(btn_poll_ms);
        end
      end
      HADC_JACK_IN, HADC_BTN_CHECK: begin
        if (!jack_s) begin
          d.state = HADC_REM_DEB;
          t_load = 1'b1;
          t_ms = rem_deb_ms(rem_deb_sel);
        end else begin
          if (t_done) begin
            t_load = 1'b1;
            t_ms = poll_ms(btn_poll_ms);
            d.adc_req = btn_poll_en && q.jack_type;
          end
          if (adc_valid && btn_poll_en && q.jack_type) begin
            d.btn_result = adc_data;
            if (q.state == HADC_JACK_IN && btn != HADC_BTN_MIC) begin
              ev_set[`HADC_EV_PRESS_BASE + int'(btn[1:0])] = 1'b1;
              d.held_btn = btn[1:0];
              d.state = HADC_BTN_CHECK;
            end else if (q.state == HADC_BTN_CHECK && btn == HADC_BTN_MIC) begin
              ev_set[`HADC_EV_RELEASE_BASE + int'(q.held_btn)] = 1'b1;
              d.state = HADC_JACK_IN;
            end
          end
        end
      end
      HADC_REM_DEB: begin
        if (jack_s) begin
          // bounce back: run detection again from the start
          d.state = HADC_DETECT;
          d.order_phase = 1'b0;
          t_load = 1'b1;
          t_ms = lat3_ms(detect_rate_sel);
        end else if (t_done) begin
          ev_set[`HADC_EV_REMOVED] = 1'b1;
          d.present = 1'b0;
          d.jack_type = `HADC_TYPE_RST;
          d.pin_order = `HADC_ORDER_RST;
          d.auto_bias = 1'b0;
          d.held_btn = '0;
          d.state = HADC_NO_JACK;
        end
      end
      default: begin
        d.state = HADC_NO_JACK;
      end
    endcase
    d.events = ev_keep | ev_set;
    d.irq = |(d.events & ~evt_mask);
    d.bias_drive = d.auto_bias & bias_rail_enable;
    d.bias_isolate = ~d.bias_drive;
    d.bias_up = q.bias_drive;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.state <= HADC_NO_JACK;
      q.bias_isolate <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign accdet_state = q.state;
  assign events = q.events;
  assign jack_present = q.present;
  assign jack_type = q.jack_type;
  assign pin_order = q.pin_order;
  assign gnd_switch = q.gnd_switch;
  assign bias_drive = q.bias_drive;
  assign bias_isolate = q.bias_isolate;
  assign bias_up = q.bias_up;
  assign btn_result = q.btn_result;
  assign adc_req = q.adc_req;
  assign host_irq_out = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_irq_set;
    |(events & ~$past(evt_mask)) |-> host_irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq low with unmasked event");

  property p_irq_clear;
    !(|(events & ~$past(evt_mask))) && $past(host_irq_out) |-> !host_irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq high with no unmasked event");

  property p_w1c_keep;
    |ev_keep |=> ((events & $past(ev_keep)) == $past(ev_keep));
  endproperty
  a_w1c_keep: assert property (p_w1c_keep) else $error("event lost without clear");

  property p_insert;
    accdet_state == HADC_INS_DEB ##1 accdet_state == HADC_DETECT |-> events[`HADC_EV_INSERTED] && jack_present;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion not flagged");

  property p_remove;
    accdet_state == HADC_REM_DEB ##1 accdet_state == HADC_NO_JACK
      |-> events[`HADC_EV_REMOVED] && !jack_present && !jack_type && !pin_order;
  endproperty
  a_remove: assert property (p_remove) else $error("removal not handled");

  property p_bias_off;
    accdet_state == HADC_REM_DEB ##1 accdet_state == HADC_NO_JACK |-> !bias_drive ##1 bias_isolate && !bias_up;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias not removed");

  property p_bias_gate;
    !bias_rail_enable |=> !bias_drive;
  endproperty
  a_bias_gate: assert property (p_bias_gate) else $error("bias on without host enable");

  property p_bias_up;
    bias_drive |=> bias_up;
  endproperty
  a_bias_up: assert property (p_bias_up) else $error("bias up status late");

  property p_gnd_four;
    gnd_switch |-> jack_type && accdet_state == HADC_DETECT;
  endproperty
  a_gnd_four: assert property (p_gnd_four) else $error("ground switching on three-pole");

  property p_press;
    accdet_state == HADC_JACK_IN ##1 accdet_state == HADC_BTN_CHECK |-> |events[6:3];
  endproperty
  a_press: assert property (p_press) else $error("press without event");

  c_insert: cover property (accdet_state == HADC_INS_DEB ##1 accdet_state == HADC_DETECT);
  c_four: cover property (accdet_state == HADC_DETECT && gnd_switch);
  c_press: cover property (accdet_state == HADC_BTN_CHECK ##1 accdet_state == HADC_JACK_IN);
  c_remove: cover property (accdet_state == HADC_REM_DEB ##1 accdet_state == HADC_NO_JACK);

endmodule

// >>> src/hadc_cfg.svh
// constants of the headset accessory detect controller
`ifndef HADC_CFG_SVH
`define HADC_CFG_SVH

// clock and millisecond tick
`define HADC_CLK_PERIOD_NS 100
`define HADC_MS_NS 1000000
`define HADC_TICK_CYCLES (`HADC_MS_NS / `HADC_CLK_PERIOD_NS)

// event flag positions
`define HADC_EV_W 11
`define HADC_EV_INSERTED 0
`define HADC_EV_REMOVED 1
`define HADC_EV_COMPLETE 2
`define HADC_EV_PRESS_BASE 3
`define HADC_EV_RELEASE_BASE 7

// insertion debounce in ms, codes 000 to 111
`define HADC_INS_DEB_0 10'd5
`define HADC_INS_DEB_1 10'd10
`define HADC_INS_DEB_2 10'd20
`define HADC_INS_DEB_3 10'd50
`define HADC_INS_DEB_4 10'd100
`define HADC_INS_DEB_5 10'd200
`define HADC_INS_DEB_6 10'd500
`define HADC_INS_DEB_7 10'd1000
`define HADC_INS_DEB_RST 3'h2

// removal debounce in ms, codes 00 to 11
`define HADC_REM_DEB_0 10'd1
`define HADC_REM_DEB_1 10'd5
`define HADC_REM_DEB_2 10'd10
`define HADC_REM_DEB_3 10'd20
`define HADC_REM_DEB_RST 2'h0

// detection latency at rate code 00, in ms
`define HADC_LAT3_BASE 10'd32
`define HADC_LAT4_BASE 10'd64

// button poll interval limits in ms
`define HADC_POLL_MIN 9'd2
`define HADC_POLL_MAX 9'd500

// reset values of status fields
`define HADC_TYPE_RST 1'b0
`define HADC_ORDER_RST 1'b0

`endif

// >>> src/hadc_pkg.sv
// types of the headset accessory detect controller
package hadc_pkg;

  typedef enum logic [2:0] {
    HADC_NO_JACK = 3'b000,
    HADC_INS_DEB = 3'b001,
    HADC_DETECT = 3'b010,
    HADC_JACK_IN = 3'b011,
    HADC_BTN_CHECK = 3'b100,
    HADC_REM_DEB = 3'b101
  } hadc_state_type;

  typedef enum logic [2:0] {
    HADC_BTN_A = 3'b000,
    HADC_BTN_B = 3'b001,
    HADC_BTN_C = 3'b010,
    HADC_BTN_D = 3'b011,
    HADC_BTN_MIC = 3'b100
  } hadc_btn_type;

  typedef struct packed {
    hadc_state_type state;
    logic sync1;
    logic sync2;
    logic [10:0] events;
    logic present;
    logic jack_type;
    logic pin_order;
    logic order_phase;
    logic gnd_switch;
    logic auto_bias;
    logic bias_drive;
    logic bias_isolate;
    logic bias_up;
    logic [1:0] held_btn;
    logic [7:0] btn_result;
    logic adc_req;
    logic irq;
  } hadc_state_reg_type;

endpackage

// >>> src/hadc_msdly.sv
// millisecond delay timer with prescaler
`timescale 1ns/100ps
`include "hadc_cfg.svh"

module hadc_msdly #(
  parameter int TICK_CYCLES = `HADC_TICK_CYCLES,
  parameter int MS_W = 10
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [MS_W-1:0] load_ms,
  output logic done
);

  localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] ms;
    logic run;
    logic done;
  } hadc_msdly_reg_type;

  hadc_msdly_reg_type q, d;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("hadc_msdly: TICK_CYCLES must be at least 1");
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (load) begin
      d.pre = '0;
      d.ms = load_ms;
      d.run = (load_ms != '0);
    end else if (q.run) begin
      if (q.pre == PRE_LAST) begin
        d.pre = '0;
        if (q.ms == MS_W'(1)) begin
          d.run = 1'b0;
          d.done = 1'b1;
        end else begin
          d.ms = q.ms - MS_W'(1);
        end
      end else begin
        d.pre = q.pre + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule

// >>> sim/hadc_jack_model.sv
// behavioural jack socket with plugged accessory for the detect controller
`timescale 1ns/100ps

module hadc_jack_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic plugged,
  input wire logic four_pole,
  input wire logic mic_first,
  input wire logic pin_high_in,
  input wire logic slow,
  input wire logic [7:0] btn_v,
  input wire logic adc_req,
  output logic jack_det_pin,
  output logic type_meas_four,
  output logic order_meas_mic_first,
  output logic adc_valid,
  output logic [7:0] adc_data
);
  logic [2:0] wait_q;
  logic pend_q;
  logic tog_q;
  // socket pull returns the pin to its idle level once the plug is out
  assign jack_det_pin = plugged ? pin_high_in : ~pin_high_in;
  // with no plug the measurements carry no meaning, so they wander
  assign type_meas_four = plugged ? four_pole : tog_q;
  assign order_meas_mic_first = plugged ? mic_first : tog_q;
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 3'h0;
      pend_q <= 1'b0;
      tog_q <= 1'b0;
      adc_valid <= 1'b0;
      adc_data <= 8'h00;
    end else begin
      tog_q <= ~tog_q;
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_req) begin
        pend_q <= 1'b1;
        wait_q <= slow ? 3'h5 : 3'h0;
      end else if (pend_q && wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        adc_valid <= 1'b1;
        adc_data <= btn_v;
      end
    end
  end
endmodule

// >>> sim/hadc_ctrl_tb.sv
// self-checking testbench of the headset accessory detect controller
`timescale 1ns/100ps

module hadc_ctrl_tb;
  import hadc_pkg::*;
  localparam int T = 10;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic plugged = 1'b0, four_pole = 1'b0, mic_first = 1'b0, pin_high_in = 1'b1, slow = 1'b0;
  logic [7:0] btn_v = 8'h80;
  logic accdet_enable = 1'b1, type_det_auto = 1'b1, type_force = 1'b0, order_det_auto = 1'b1;
  logic order_force = 1'b0, btn_poll_en = 1'b0, bias_rail_enable = 1'b0;
  logic [2:0] ins_deb_sel = 3'h0;
  logic [1:0] rem_deb_sel = 2'h0, detect_rate_sel = 2'h0;
  logic [8:0] btn_poll_ms = 9'h002;
  logic [7:0] thr_a_d = 8'h20, thr_d_b = 8'h40, thr_b_c = 8'h60, thr_c_mic = 8'h80;
  logic [10:0] evt_clear = 11'h000, evt_mask = 11'h000, events;
  logic jack_det_pin, type_meas_four, order_meas_mic_first, adc_valid, adc_req, host_irq_out;
  logic [7:0] adc_data, btn_result;
  logic jack_present, jack_type, pin_order, gnd_switch, bias_drive, bias_isolate, bias_up;
  hadc_state_type accdet_state;
  logic gnd_seen = 1'b0;
  int fail_count = 0, n_compared = 0, n;
  int dtab[8] = '{5, 10, 20, 50, 100, 200, 500, 1000};
  int rtab[4] = '{1, 5, 10, 20};
  logic [7:0] vtab[4] = '{8'h1f, 8'h40, 8'h60, 8'h20};

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (gnd_switch === 1'b1) gnd_seen <= 1'b1;

  hadc_jack_model jack (.core_clk, .rstn, .plugged, .four_pole, .mic_first, .pin_high_in, .slow, .btn_v,
    .adc_req, .jack_det_pin, .type_meas_four, .order_meas_mic_first, .adc_valid, .adc_data);
  hadc_ctrl #(.TICK_CYCLES(T)) dut (.core_clk, .rstn, .jack_det_pin, .jack_det_active_high(pin_high_in),
    .accdet_enable, .ins_deb_sel, .rem_deb_sel, .detect_rate_sel, .type_det_auto, .type_force,
    .type_meas_four, .order_det_auto, .order_force, .order_meas_mic_first, .btn_poll_en, .btn_poll_ms,
    .thr_a_d, .thr_d_b, .thr_b_c, .thr_c_mic, .adc_valid, .adc_data, .bias_rail_enable, .evt_clear,
    .evt_mask, .accdet_state, .events, .jack_present, .jack_type, .pin_order, .gnd_switch, .bias_drive,
    .bias_isolate, .bias_up, .btn_result, .adc_req, .host_irq_out);
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_win(input string what, input int lo, input int got);
    n_compared++;
    if (got < lo || got > lo + 8) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, lo + 8, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic wait_ev(input int idx, output int cyc);
    cyc = 0;
    while (events[idx] !== 1'b1 && cyc < 12000) begin
      tick(1);
      cyc++;
    end
    if (cyc >= 12000) begin
      fail_count++;
      $display("[ERR] event %0d expected set seen timeout", idx);
    end
  endtask

  task automatic wait_req(output int cyc);
    cyc = 0;
    while (adc_req !== 1'b1 && cyc < 2000) begin
      tick(1);
      cyc++;
    end
    if (cyc >= 2000) begin
      fail_count++;
      $display("[ERR] adc_req expected pulse seen timeout");
    end
  endtask

  task automatic clear_ev(input logic [10:0] bits);
    evt_clear = bits;
    tick(1);
    evt_clear = 11'h000;
    tick(1);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
    tick(2);
    check("state after reset", HADC_NO_JACK, accdet_state);
    check("bias after reset", 3'b001, {bias_drive, bias_up, bias_isolate});
    // every debounce, rate, polarity and order code with alternating pole count
    for (int i = 0; i < 8; i++) begin
      ins_deb_sel = i[2:0];
      rem_deb_sel = i[1:0];
      detect_rate_sel = i[1:0];
      four_pole = i[0];
      pin_high_in = ~i[1];
      mic_first = i[2];
      tick(1);
      gnd_seen = 1'b0;
      plugged = 1'b1;
      wait_ev(0, n);
      check_win("insert debounce", dtab[i] * T, n);
      check("present", 1'b1, jack_present);
      wait_ev(2, n);
      check_win("detect latency", (32 << i[1:0]) * T * (i[0] ? 2 : 1), n);
      check("type", i[0], jack_type);
      check("order", i[0] & i[2], pin_order);
      check("ground switch use", i[0], gnd_seen);
      check("bias held off", 1'b0, bias_drive);
      check("state", HADC_JACK_IN, accdet_state);
      check("irq", 1'b1, host_irq_out);
      clear_ev(11'h001);
      check("irq one left", 1'b1, host_irq_out);
      check("complete kept", 11'h004, events);
      clear_ev(11'h004);
      check("irq cleared", 1'b0, host_irq_out);
      plugged = 1'b0;
      wait_ev(1, n);
      check_win("remove debounce", rtab[i[1:0]] * T, n);
      check("removed status", 4'h0, {jack_present, jack_type, pin_order, bias_up});
      clear_ev(11'h002);
    end
    // forced type and order, all masked, bias allowed, buttons polled at the 2 ms minimum with a slow adc
    four_pole = 1'b0;
    mic_first = 1'b0;
    type_det_auto = 1'b0;
    type_force = 1'b1;
    order_det_auto = 1'b0;
    order_force = 1'b1;
    ins_deb_sel = 3'h0;
    detect_rate_sel = 2'h0;
    evt_mask = 11'h7ff;
    bias_rail_enable = 1'b1;
    btn_poll_en = 1'b1;
    btn_poll_ms = 9'h001;
    slow = 1'b1;
    gnd_seen = 1'b0;
    plugged = 1'b1;
    wait_ev(2, n);
    check("forced type", 1'b1, jack_type);
    check("forced order", 1'b1, pin_order);
    check("masked irq", 1'b0, host_irq_out);
    check("masked flags", 11'h005, events);
    check("no ground switch when forced", 1'b0, gnd_seen);
    evt_mask = 11'h7fe;
    tick(1);
    check("single source unmasked", 1'b1, host_irq_out);
    evt_mask = 11'h7ff;
    tick(1);
    check("masked again", 1'b0, host_irq_out);
    tick(2);
    check("bias on", 3'b110, {bias_drive, bias_up, bias_isolate});
    wait_req(n);
    tick(1);
    wait_req(n);
    check_win("poll interval", 2 * T - 2, n);
    for (int b = 0; b < 4; b++) begin
      btn_v = vtab[b];
      wait_ev(3 + b, n);
      check("press state", HADC_BTN_CHECK, accdet_state);
      check("adc result", vtab[b], btn_result);
      btn_v = 8'h80;
      wait_ev(7 + b, n);
      check("button events", 11'h005 | (11'h088 << b), events);
      clear_ev(11'h088 << b);
    end
    btn_v = 8'h1f;
    wait_ev(3, n);
    plugged = 1'b0;
    wait_ev(1, n);
    tick(2);
    check("bias off on removal", 3'b001, {bias_drive, bias_up, bias_isolate});
    check("removed state", HADC_NO_JACK, accdet_state);
    summarize();
  end

  initial begin
    repeat (80000) @(posedge core_clk);
    fail_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    summarize();
  end
endmodule
